// File: fssp_consts.vh
// Constants for the framer serial system port
`ifndef FSSP_CONSTS_VH
`define FSSP_CONSTS_VH
// =====================================================
// Reference clock select codes, transmit marker
`define FSSP_TREF_TX_CLOCK_IN   3'h0
`define FSSP_TREF_TX_LINE_CLOCK 3'h1
`define FSSP_TREF_TX_CLOCK_OUT  3'h2
`define FSSP_TREF_RX_CLOCK_OUT  3'h3
`define FSSP_TREF_RX_LINE_CLOCK 3'h4
// =====================================================
// Receive clock pin mode and receive reference select
`define FSSP_RCLK_PLAIN   2'h0
`define FSSP_RCLK_GAPPED  2'h1
`define FSSP_RCLK_LINE    2'h2
`define FSSP_RREF_CLOCK_OUT 1'h0
`define FSSP_RREF_LINE      1'h1
// =====================================================
// Marker lead in reference clocks
`define FSSP_LEAD_CLOCKS  4'h3
`define FSSP_LEAD_W       4
// =====================================================
// Default frame layout in bits (simplified DS3 subframe)
`define FSSP_FRAME_BITS   16'h02A8
`define FSSP_BLOCK_BITS   16'h0055
`define FSSP_CNT_W        16
`endif

// File: fssp_edge_sync.v
// Three stage synchroniser with rise and fall detection for a sampled clock
module fssp_edge_sync (
   input  wire clk_sys,
   input  wire reset,
   input  wire din,
   output reg  level_reg,
   output reg  rise_reg,
   output reg  fall_reg
);
   reg s1_reg;
   reg s2_reg;
   reg s3_reg;
   // =====================================================
   // Stage one only feeds stage two; change taken when two and three agree
   always @(posedge clk_sys) begin
      if (reset) begin
         s1_reg    <= 1'b0;
         s2_reg    <= 1'b0;
         s3_reg    <= 1'b0;
         level_reg <= 1'b0;
         rise_reg  <= 1'b0;
         fall_reg  <= 1'b0;
      end else begin
         s1_reg   <= din;
         s2_reg   <= s1_reg;
         s3_reg   <= s2_reg;
         rise_reg <= 1'b0;
         fall_reg <= 1'b0;
         if (s2_reg == s3_reg && s3_reg != level_reg) begin
            level_reg <= s3_reg;
            rise_reg  <= s3_reg;
            fall_reg  <= ~s3_reg;
         end
      end
   end
endmodule // fssp_edge_sync

// File: fssp_port.v
// Framer serial system port: transmit markers, receive data, clock and markers
// Overview of operation
// R1: Frame-start output pulses three reference clocks before first overhead bit.
// R2: Payload window rises three reference clocks before payload bits begin.
// R3: Payload window falls three reference clocks before payload bits end.
// R4: Shared transmit pin carries frame-start or window, only in framed modes.
// R5: Outputs update on rising reference edge, falling edge when clock inverted.
// R6: Transmit marker reference selectable among five clocks, default transmit clock.
// R7: Framed modes put receive line data on receive serial output.
// R8: Receive serial timed by clock out, gapped clock, or line clock; code selects only rx_framer_clock or rx_line_clock edges, no gapped clock.
// R9: Plain mode drives internal receive framer clock on receive clock pin.
// R10: Receive clock output usable as reference for transmit and receive signals.
// R11: Gapped mode gates receive framer clock with receive payload window.
// R12: Receive frame-start high exactly during first overhead bit of frame.
// R13: Receive marker timed by receive clock out or receive line clock.
// R14: Receive window function marks payload bits on shared receive marker pin.
// R15: Receive window high on payload bits, low on overhead bits.
// R16: Each output has its own polarity inversion option.
// R17: External logic aligns transmit data to markers; three clocks after pulse.
`include "fssp_consts.vh"
module fssp_port #(
   parameter [`FSSP_CNT_W-1:0] FRAME_BITS = `FSSP_FRAME_BITS,
   parameter [`FSSP_CNT_W-1:0] BLOCK_BITS = `FSSP_BLOCK_BITS
) (
   input  wire       clk_sys,
   input  wire       reset,
   input  wire       framed_mode,
   input  wire       tx_marker_is_window,
   input  wire [2:0] tx_ref_select,
   input  wire       tx_ref_invert,
   input  wire       tx_marker_invert,
   input  wire [1:0] rx_clock_mode,
   input  wire       rx_ser_ref_line,
   input  wire       rx_marker_ref_line,
   input  wire       rx_ref_invert,
   input  wire       rx_marker_is_window,
   input  wire       rx_serial_invert,
   input  wire       rx_clock_invert,
   input  wire       rx_gapped_invert,
   input  wire       rx_marker_invert,
   input  wire       tx_clock_in,
   input  wire       tx_line_clock,
   input  wire       tx_clock_out,
   input  wire       rx_line_clock,
   input  wire       rx_framer_clock,
   input  wire       rx_line_data,
   output reg        tx_marker_out,
   output reg        rx_serial_out,
   output reg        rx_clock_out,
   output reg        rx_marker_out
);
   // =====================================================
   // Sampled clocks and data
   wire txc_l, txc_r, txc_f, tlc_l, tlc_r, tlc_f, tco_l, tco_r, tco_f;
   wire rlc_l, rlc_r, rlc_f, rfc_l, rfc_r, rfc_f, rld_l;
   fssp_edge_sync u_txc (.clk_sys(clk_sys), .reset(reset), .din(tx_clock_in),
      .level_reg(txc_l), .rise_reg(txc_r), .fall_reg(txc_f));
   fssp_edge_sync u_tlc (.clk_sys(clk_sys), .reset(reset), .din(tx_line_clock),
      .level_reg(tlc_l), .rise_reg(tlc_r), .fall_reg(tlc_f));
   fssp_edge_sync u_tco (.clk_sys(clk_sys), .reset(reset), .din(tx_clock_out),
      .level_reg(tco_l), .rise_reg(tco_r), .fall_reg(tco_f));
   fssp_edge_sync u_rlc (.clk_sys(clk_sys), .reset(reset), .din(rx_line_clock),
      .level_reg(rlc_l), .rise_reg(rlc_r), .fall_reg(rlc_f));
   fssp_edge_sync u_rfc (.clk_sys(clk_sys), .reset(reset), .din(rx_framer_clock),
      .level_reg(rfc_l), .rise_reg(rfc_r), .fall_reg(rfc_f));
   fssp_edge_sync u_rld (.clk_sys(clk_sys), .reset(reset), .din(rx_line_data),
      .level_reg(rld_l), .rise_reg(), .fall_reg());

   // =====================================================
   // Reference edge selection
   reg tx_edge;
   always @* begin
      case (tx_ref_select) // see R6 // see R10
         `FSSP_TREF_TX_LINE_CLOCK: tx_edge = tx_ref_invert ? tlc_f : tlc_r;
         `FSSP_TREF_TX_CLOCK_OUT:  tx_edge = tx_ref_invert ? tco_f : tco_r;
         `FSSP_TREF_RX_CLOCK_OUT:  tx_edge = tx_ref_invert ? rfc_f : rfc_r;
         `FSSP_TREF_RX_LINE_CLOCK: tx_edge = tx_ref_invert ? rlc_f : rlc_r;
         default:                  tx_edge = tx_ref_invert ? txc_f : txc_r; // see R5
      endcase
   end
   // Receive framer runs on its own clock; line clock or clock out as reference
   wire rf_edge  = rx_ref_invert ? rfc_f : rfc_r;
   wire rl_edge  = rx_ref_invert ? rlc_f : rlc_r;
   wire ser_edge = rx_ser_ref_line ? rl_edge : rf_edge; // see R8
   wire mk_edge  = rx_marker_ref_line ? rl_edge : rf_edge; // see R13

   // =====================================================
   // Transmit frame position counter on the transmit reference; markers decoded three clocks ahead
   reg [`FSSP_CNT_W-1:0] tx_pos_reg;
   reg [`FSSP_CNT_W-1:0] tx_blk_reg;
   wire tx_oh = (tx_blk_reg == {`FSSP_CNT_W{1'b0}});
   // Counter positions match the bit at the serial input; marks are decoded LEAD ahead
   always @(posedge clk_sys) begin
      if (reset) begin
         tx_pos_reg <= {`FSSP_CNT_W{1'b0}};
         tx_blk_reg <= {`FSSP_CNT_W{1'b0}};
      end else if (tx_edge) begin
         if (tx_pos_reg == FRAME_BITS - 1'b1) begin
            tx_pos_reg <= {`FSSP_CNT_W{1'b0}};
            tx_blk_reg <= {`FSSP_CNT_W{1'b0}};
         end else begin
            tx_pos_reg <= tx_pos_reg + 1'b1;
            tx_blk_reg <= (tx_blk_reg == BLOCK_BITS - 1'b1) ? {`FSSP_CNT_W{1'b0}}
                                                          : tx_blk_reg + 1'b1;
         end
      end
   end
   // Position LEAD before the next frame start in counted bits
   wire [`FSSP_CNT_W-1:0] sof_pos = FRAME_BITS - {{(`FSSP_CNT_W-`FSSP_LEAD_W){1'b0}},
                                                  `FSSP_LEAD_CLOCKS};
   // Window mark for the bit three clocks later in the frame
   reg [`FSSP_CNT_W-1:0] ahead_blk;
   always @* begin
      if (tx_blk_reg + `FSSP_LEAD_CLOCKS >= BLOCK_BITS)
         ahead_blk = tx_blk_reg + `FSSP_LEAD_CLOCKS - BLOCK_BITS;
      else
         ahead_blk = tx_blk_reg + `FSSP_LEAD_CLOCKS;
   end
   wire ahead_wrap = (tx_pos_reg >= sof_pos);
   wire ahead_pay  = ahead_wrap ? (tx_pos_reg != sof_pos)
                                : (ahead_blk != {`FSSP_CNT_W{1'b0}});
   wire tx_mark = tx_marker_is_window ? ahead_pay // see R2 // see R3
                                      : (tx_pos_reg == sof_pos); // see R1 // see R17
   always @(posedge clk_sys) begin
      if (reset) begin
         tx_marker_out <= 1'b0;
      end else if (tx_edge) begin
         tx_marker_out <= (framed_mode & tx_mark) ^ tx_marker_invert; // see R4 // see R16
      end
   end

   // =====================================================
   // Receive frame position counter on the receive framer clock
   reg [`FSSP_CNT_W-1:0] rx_pos_reg;
   reg [`FSSP_CNT_W-1:0] rx_blk_reg;
   wire rx_first = (rx_pos_reg == {`FSSP_CNT_W{1'b0}});
   wire rx_pay   = (rx_blk_reg != {`FSSP_CNT_W{1'b0}}); // see R15
   reg  rx_pay_reg;
   always @(posedge clk_sys) begin
      if (reset) begin
         rx_pos_reg <= {`FSSP_CNT_W{1'b0}};
         rx_blk_reg <= {`FSSP_CNT_W{1'b0}};
         rx_pay_reg <= 1'b0;
      end else if (rf_edge) begin
         rx_pay_reg <= rx_pay;
         if (rx_pos_reg == FRAME_BITS - 1'b1) begin
            rx_pos_reg <= {`FSSP_CNT_W{1'b0}};
            rx_blk_reg <= {`FSSP_CNT_W{1'b0}};
         end else begin
            rx_pos_reg <= rx_pos_reg + 1'b1;
            rx_blk_reg <= (rx_blk_reg == BLOCK_BITS - 1'b1) ? {`FSSP_CNT_W{1'b0}}
                                                          : rx_blk_reg + 1'b1;
         end
      end
   end

   // =====================================================
   // Receive outputs
   always @(posedge clk_sys) begin
      if (reset) begin
         rx_serial_out <= 1'b0;
         rx_marker_out <= 1'b0;
      end else begin
         if (ser_edge)
            rx_serial_out <= (framed_mode & rld_l) ^ rx_serial_invert; // see R7 // see R8
         if (mk_edge)
            rx_marker_out <= (framed_mode & (rx_marker_is_window ? rx_pay : rx_first))
                             ^ rx_marker_invert; // see R12 // see R14 // see R15 // see R16
      end
   end
   // Clock pin is a resampled copy, so its edges lag the framer or line clock it copies
   always @(posedge clk_sys) begin
      if (reset) begin
         rx_clock_out <= 1'b0;
      end else begin
         case (rx_clock_mode)
            `FSSP_RCLK_GAPPED: rx_clock_out <= (framed_mode & rfc_l & rx_pay_reg)
                                               ^ rx_gapped_invert; // see R11 // see R16
            `FSSP_RCLK_LINE:   rx_clock_out <= rlc_l ^ rx_clock_invert;
            default:           rx_clock_out <= (framed_mode & rfc_l)
                                               ^ rx_clock_invert; // see R9 // see R10
         endcase
      end
   end
endmodule // fssp_port

// File: fssp_line_model.sv
// Far-side model: free-running framer and line clock plus receive line data
module fssp_line_model (
   output logic ref_clk,
   output logic line_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] lfsr;
   // ====================
   // Framer clocks run free, so no stop between frames
   initial begin
      ref_clk = 1'b0;
      line_data = 1'b0;
      lfsr = 4'h9;
      // Offset keeps clock and data edges off the sampling clock edges
      #2;
      forever #32 ref_clk = ~ref_clk;
   end
   // Data moves just after the rising edge, stable for a whole bit
   always @(posedge ref_clk) begin
      #1;
      lfsr = {lfsr[2:0], lfsr[3] ^ lfsr[2]};
      line_data = lfsr[0];
   end
endmodule // fssp_line_model

// File: fssp_port_checker.sv
// Assertion checker for the framer serial system port
`include "fssp_consts.vh"
module fssp_port_checker #(
   parameter [`FSSP_CNT_W-1:0] FRAME_BITS = `FSSP_FRAME_BITS,
   parameter [`FSSP_CNT_W-1:0] BLOCK_BITS = `FSSP_BLOCK_BITS
) (
   input wire logic       clk_sys,
   input wire logic       reset,
   input wire logic       framed_mode,
   input wire logic       tx_marker_is_window,
   input wire logic [2:0] tx_ref_select,
   input wire logic       tx_ref_invert,
   input wire logic       tx_marker_invert,
   input wire logic [1:0] rx_clock_mode,
   input wire logic       rx_marker_ref_line,
   input wire logic       rx_ref_invert,
   input wire logic       rx_marker_is_window,
   input wire logic       rx_serial_invert,
   input wire logic       rx_clock_invert,
   input wire logic       rx_marker_invert,
   input wire logic       tx_clock_in,
   input wire logic       rx_framer_clock,
   input wire logic       rx_line_clock,
   input wire logic       tx_marker_out,
   input wire logic       rx_serial_out,
   input wire logic       rx_clock_out,
   input wire logic       rx_marker_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // ====================
   // Helpers: quiet time after config change, cycles since active tx_clock_in edge
   logic [7:0]  quiet_reg;
   logic [7:0]  since_reg;
   logic [1:0]  tck_reg;
   logic [15:0] cfg_reg;
   wire  [15:0] cfg = {framed_mode, tx_marker_is_window, tx_ref_select, tx_ref_invert,
      tx_marker_invert, rx_clock_mode, rx_marker_ref_line, rx_ref_invert,
      rx_marker_is_window, rx_serial_invert, rx_clock_invert, rx_marker_invert};
   always @(posedge clk_sys) begin
      cfg_reg <= cfg;
      tck_reg <= {tck_reg[0], tx_clock_in};
      quiet_reg <= (reset || cfg != cfg_reg) ? 8'h00 : quiet_reg + {7'h00, quiet_reg != 8'hFF};
      since_reg <= (tck_reg == {tx_ref_invert, ~tx_ref_invert}) ? 8'h00 :
         since_reg + {7'h00, since_reg != 8'hFF};
   end
   // ====================
   // Checks; a config change masks them while the sync pipes refill
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset || cfg != cfg_reg || quiet_reg < 8'h14);
   unframed_a:
      assert property (!framed_mode |-> {tx_marker_out, rx_marker_out, rx_serial_out} ==
         {tx_marker_invert, rx_marker_invert, rx_serial_invert}) else $error("idle level wrong");
   tx_pulse_a:
      assert property (!tx_marker_is_window && !tx_marker_invert && $rose(tx_marker_out)
         |-> tx_marker_out[*8] ##1 !tx_marker_out) else $error("tx pulse width wrong");
   tx_win_a:
      assert property (tx_marker_is_window && !tx_marker_invert && $fell(tx_marker_out)
         |-> !tx_marker_out[*8] ##1 tx_marker_out) else $error("tx window gap wrong");
   tx_edge_a:
      assert property (tx_ref_select == 3'h0 && $changed(tx_marker_out)
         |-> since_reg inside {[8'h02:8'h07]}) else $error("tx marker off its edge");
   rx_pulse_a:
      assert property (!rx_marker_is_window && !rx_marker_invert && $rose(rx_marker_out)
         |-> rx_marker_out[*8] ##1 !rx_marker_out) else $error("rx pulse width wrong");
   rx_win_a:
      assert property (rx_marker_is_window && !rx_marker_invert && $fell(rx_marker_out)
         |-> !rx_marker_out[*8] ##1 rx_marker_out) else $error("rx window gap wrong");
   plain_clk_a:
      assert property (framed_mode && rx_clock_mode == 2'h0 && $rose(rx_framer_clock)
         |-> ##[3:7] (rx_clock_out ^ rx_clock_invert)) else $error("rx clock not copied");
   line_clk_a:
      assert property (rx_clock_mode == 2'h2 && $rose(rx_line_clock)
         |-> ##[3:7] (rx_clock_out ^ rx_clock_invert)) else $error("line clock not copied");
   cover property (tx_marker_is_window && $fell(tx_marker_out));
   cover property (rx_clock_mode == 2'h1 && $rose(rx_clock_out));
   cover property (!rx_marker_is_window && $rose(rx_marker_out));
endmodule // fssp_port_checker

// File: fssp_port_test.sv
// Self-checking bench for the framer serial system port
`define FT_CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
   $display("BAD %s exp %0d got %0d", nm, e, g); end end
module fssp_port_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam [15:0] FRAME_BITS = 16'h0010;
   localparam [15:0] BLOCK_BITS = 16'h0004;
   logic clk_sys = 0, reset = 1, framed_mode = 1, tx_marker_is_window = 0, tx_ref_invert = 0;
   logic tx_marker_invert = 0, rx_ser_ref_line = 0, rx_marker_ref_line = 0, rx_ref_invert = 0;
   logic rx_marker_is_window = 0, rx_serial_invert = 0, rx_clock_invert = 0;
   logic rx_gapped_invert = 0, rx_marker_invert = 0, ref_clk, rx_line_data, ie = 0;
   logic [2:0] tx_ref_select = 3'h0;
   logic [1:0] rx_clock_mode = 2'h0;
   logic [4:0] en = 5'h01;
   wire  tx_clock_in, tx_line_clock, tx_clock_out, rx_line_clock, rx_framer_clock;
   wire  tx_marker_out, rx_serial_out, rx_clock_out, rx_marker_out;
   int   failures = 0, comparisons = 0, cycles = 0, ne = 0, ntx, nrx, nck, ph;
   int   rxe[8] = '{2, 30, 2, 30, 24, 8, 24, 8};
   // Only the enabled reference runs, so a wrong select shows as a dead marker
   assign {rx_line_clock, rx_framer_clock, tx_clock_out, tx_line_clock, tx_clock_in} =
      en & {5{ref_clk}};
   fssp_line_model i_fssp_line_model (.ref_clk(ref_clk), .line_data(rx_line_data));
   fssp_port #(.FRAME_BITS(FRAME_BITS), .BLOCK_BITS(BLOCK_BITS)) i_fssp_port (.*);
   always #4 clk_sys = ~clk_sys;
   always @(negedge ref_clk) ne++;
   always @(posedge rx_clock_out) nck++;
   task close_out;
      $display("failures %0d comparisons %0d", failures, comparisons);
      if (failures == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         close_out();
      end
   end
   // Sample at the active edge, where the last update has settled
   task automatic grab(input int md);
      ntx = 0;
      nrx = 0;
      repeat (16) @(posedge (ref_clk ^ ie));
      nck = 0;
      repeat (32) begin
         @(posedge (ref_clk ^ ie));
         ntx += tx_marker_out;
         nrx += rx_marker_out;
         if (md == 1 && tx_marker_out === 1'b1) ph = ne % 4;
         if (md == 2) `FT_CHK("window", (ne % 4) != ph, tx_marker_out)
         if (md == 3) `FT_CHK("serial", rx_line_data ^ rx_serial_invert, rx_serial_out)
      end
   endtask
   task automatic tx_cfg(input logic w, input logic [2:0] s, input logic i, input logic v);
      @(negedge clk_sys);
      {tx_marker_is_window, tx_ref_select, tx_ref_invert, tx_marker_invert, ie} = {w, s, i, v, i};
      en = 5'h01 << s;
   endtask
   initial begin
      repeat (20) @(negedge clk_sys);
      reset = 0;
      grab(1);
      `FT_CHK("tx_start", 2, ntx)
      tx_cfg(1'b1, 3'h0, 1'b0, 1'b0);
      grab(2);
      `FT_CHK("tx_window", 24, ntx)
      for (int k = 1; k < 10; k++) begin
         tx_cfg(1'b0, 3'(k % 5), k > 4, k[0]);
         grab(0);
         `FT_CHK("tx_start", k[0] ? 30 : 2, ntx)
      end
      for (int k = 0; k < 8; k++) begin
         @(negedge clk_sys);
         en = 5'h18;
         {rx_marker_is_window, rx_ref_invert, rx_marker_invert, ie} = {3'(k), k[1]};
         {rx_marker_ref_line, rx_ser_ref_line, rx_serial_invert} = {3{k[0]}};
         grab(k[1] ? 0 : 3);
         `FT_CHK("rx_marker", rxe[k], nrx)
      end
      for (int k = 0; k < 3; k++) begin
         @(negedge clk_sys);
         {rx_clock_mode, rx_gapped_invert, ie} = {2'(k), k[0], 1'b0};
         en = (k == 2) ? 5'h10 : 5'h18;
         grab(0);
         `FT_CHK("rx_clock", (k == 1) ? 24 : 32, nck)
      end
      @(negedge clk_sys);
      framed_mode = 0;
      grab(0);
      `FT_CHK("unframed", 64, ntx + nrx)
      close_out();
   end
endmodule // fssp_port_test
bind fssp_port fssp_port_checker #(.FRAME_BITS(FRAME_BITS), .BLOCK_BITS(BLOCK_BITS))
   i_fssp_port_checker (.*);
